//--- common/cfgprm_pkg.sv
/*
 * constants, state encodings and timing counts shared by the configuration
 * memory readout end, the loader end and the data fifo.
 * assumes one 10 MHz clock ref_clk_in on both ends of the link.
 */
package cfgprm_pkg;
   localparam int REF_CLK_HZ = 10_000_000;
   localparam int CONF_CLK_MAX_HZ = 33_000_000;
   // half period in reference cycles, rounded up so the clock stays at or below the limit
   localparam int CONF_CLK_HALF_RAW = (REF_CLK_HZ + 2 * CONF_CLK_MAX_HZ - 1) / (2 * CONF_CLK_MAX_HZ);
   localparam int CONF_CLK_HALF_CYC = (CONF_CLK_HALF_RAW < 1) ? 1 : CONF_CLK_HALF_RAW;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 256;
   localparam int LEN_W = 16;
   localparam int FIFO_DEPTH = 16;
   localparam int HALF_W = 8;
   localparam logic [3:0] RST_HOLD_CNT = 4'h4;
   localparam logic [3:0] RST_PULSE_CNT = 4'h4;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] BUS_PULL = 8'hFF;
   localparam logic MODE_BYTE = 1'b0;
   localparam logic MODE_SERIAL = 1'b1;

   typedef enum logic [3:0] {
      DEV_RESET = 4'h1,
      DEV_STANDBY = 4'h2,
      DEV_ACTIVE = 4'h4,
      DEV_PAST_END = 4'h8
   } cfgprm_dev_state_e;

   typedef enum logic [4:0] {
      LDR_IDLE = 5'h01,
      LDR_RESET = 5'h02,
      LDR_WAIT = 5'h04,
      LDR_RUN = 5'h08,
      LDR_DONE = 5'h10
   } cfgprm_ldr_state_e;
endpackage

//--- common/cfgprm_link_if.sv
/*
 * link between a configuration memory and its loader.
 * assumes both ends run on the same reference clock; open-drain reset
 * pin and data bus are resolved here from the drivers' enables.
 */
`timescale 1ns/100ps
interface cfgprm_link_if;
   import cfgprm_pkg::*;
   logic config_clock;
   logic chip_enable_n;
   logic byte_wide_mode_b;
   logic [DATA_W-1:0] data_drv;
   logic data_oe;
   logic cascade_select_out_n;
   logic rst_dev_out;
   logic rst_dev_oe;
   logic rst_ldr_out;
   logic rst_ldr_oe;
   logic reset_level;
   logic [DATA_W-1:0] parallel_data_bus;
   logic serial_data_out;

   // wired-and with pull-up, no inversion anywhere
   assign reset_level = ~((rst_dev_oe & ~rst_dev_out) | (rst_ldr_oe & ~rst_ldr_out));
   assign parallel_data_bus = data_oe ? data_drv : BUS_PULL;
   assign serial_data_out = parallel_data_bus[0];

   modport mem (
      input config_clock, chip_enable_n, byte_wide_mode_b, reset_level,
      output data_drv, data_oe, cascade_select_out_n, rst_dev_out, rst_dev_oe
   );
   modport ldr (
      output config_clock, chip_enable_n, byte_wide_mode_b, rst_ldr_out, rst_ldr_oe,
      input parallel_data_bus, serial_data_out, reset_level, cascade_select_out_n
   );
endinterface

//--- design/cfgprm_fifo.sv
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes a single clock; full and empty are exact.
 */
`timescale 1ns/100ps
module cfgprm_fifo #(
   parameter int WIDTH = cfgprm_pkg::DATA_W,
   parameter int DEPTH = cfgprm_pkg::FIFO_DEPTH,
   parameter int PTR_W = $clog2(DEPTH)
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   import cfgprm_pkg::*;

   typedef struct packed {
      logic [PTR_W-1:0] wr;
      logic [PTR_W-1:0] rd;
      logic [PTR_W:0] cnt;
   } cfgprm_fifo_s;

   logic [WIDTH-1:0] mem_r [DEPTH];
   cfgprm_fifo_s s_r;
   cfgprm_fifo_s s_nxt;
   logic push;
   logic pop;

   assign in_ready_out = (s_r.cnt != (PTR_W + 1)'(DEPTH));
   assign out_valid_out = (s_r.cnt != '0);
   assign out_data_out = mem_r[s_r.rd];
   assign push = in_valid_in & in_ready_out;
   assign pop = out_valid_out & out_ready_in;

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.wr = (s_r.wr == (PTR_W)'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
      end
      if (pop) begin
         s_nxt.rd = (s_r.rd == (PTR_W)'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
      end
      case ({push, pop})
         2'b10: s_nxt.cnt = s_r.cnt + 1'b1;
         2'b01: s_nxt.cnt = s_r.cnt - 1'b1;
         default: s_nxt.cnt = s_r.cnt;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // storage has no reset; only the pointers need one
   always_ff @(posedge ref_clk_in) begin
      if (push) begin
         mem_r[s_r.wr] <= in_data_in;
      end
   end
endmodule // cfgprm_fifo

//--- design/cfgprm_mem_end.sv
/*
 * configuration memory readout end: stored bitstream streamed one bit or
 * one byte per rising configuration clock, with cascade output.
 * assumes config_clock is a synchronous level made on ref_clk_in by the
 * loader, held at least one reference cycle in each phase.
 */
`timescale 1ns/100ps
module cfgprm_mem_end #(
   parameter int DEPTH = cfgprm_pkg::MEM_DEPTH,
   parameter int ADDR_W = $clog2(DEPTH)
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   cfgprm_link_if.mem link,
   input wire logic prog_we_in,
   input wire logic [ADDR_W-1:0] prog_addr_in,
   input wire logic [cfgprm_pkg::DATA_W-1:0] prog_data_in,
   output logic [ADDR_W-1:0] addr_out,
   output logic [2:0] bit_index_out,
   output logic standby_out,
   output logic terminal_count_out
);
   import cfgprm_pkg::*;

   typedef struct packed {
      cfgprm_dev_state_e st;
      logic clk_prev;
      logic [ADDR_W-1:0] addr;
      logic [2:0] bit_idx;
      logic terminal_count;
      logic [3:0] hold;
      logic [DATA_W-1:0] drv;
      logic oe;
      logic cso_n;
      logic rst_oe;
   } cfgprm_dev_s;

   // own reset drives the pin low from the first moment
   localparam cfgprm_dev_s DEV_INIT = '{
      st: DEV_RESET,
      clk_prev: 1'b0,
      addr: '0,
      bit_idx: 3'h0,
      terminal_count: 1'b0,
      hold: RST_HOLD_CNT,
      drv: '0,
      oe: 1'b0,
      cso_n: 1'b1,
      rst_oe: 1'b1
   };

   logic [DATA_W-1:0] mem_r [DEPTH];
   cfgprm_dev_s s_r;
   cfgprm_dev_s s_nxt;
   logic clk_rise;
   logic in_reset;
   logic byte_mode;
   logic last_addr;
   logic [DATA_W-1:0] word;

   function automatic logic pick_bit(input logic [DATA_W-1:0] w, input logic [2:0] idx);
      // most significant bit leaves first
      pick_bit = w[BIT_LAST - idx];
   endfunction

   always_comb begin
      s_nxt = s_r;
      word = '0;
      s_nxt.clk_prev = link.config_clock;
      // sampled every reference edge, so any legal clock rate is seen
      clk_rise = link.config_clock & ~s_r.clk_prev;
      byte_mode = (link.byte_wide_mode_b == MODE_BYTE);
      last_addr = (s_r.addr == (ADDR_W)'(DEPTH - 1));
      if (s_r.hold != 4'h0) begin
         s_nxt.hold = s_r.hold - 4'h1;
      end
      // the pin reads low while anyone, this end included, holds it low
      in_reset = ~link.reset_level | (s_r.hold != 4'h0);
      if (in_reset) begin
         s_nxt.st = DEV_RESET;
      end else if (link.chip_enable_n) begin
         s_nxt.st = DEV_STANDBY;
      end else if (s_r.terminal_count) begin
         s_nxt.st = DEV_PAST_END;
      end else begin
         s_nxt.st = DEV_ACTIVE;
      end
      case (s_nxt.st)
         DEV_RESET, DEV_STANDBY: begin
            // counter back to zero so the next enable starts at word zero
            s_nxt.addr = '0;
            s_nxt.bit_idx = 3'h0;
            s_nxt.terminal_count = 1'b0;
         end
         DEV_ACTIVE: begin
            if (clk_rise) begin
               if (!byte_mode && (s_r.bit_idx != BIT_LAST)) begin
                  s_nxt.bit_idx = s_r.bit_idx + 3'h1;
               end else begin
                  s_nxt.bit_idx = 3'h0;
                  if (last_addr) begin
                     s_nxt.terminal_count = 1'b1;
                  end else begin
                     s_nxt.addr = s_r.addr + 1'b1;
                  end
               end
            end
         end
         DEV_PAST_END: begin
            // counter stops; the next memory in the chain now owns the bus
            s_nxt.terminal_count = 1'b1;
         end
         default: begin
            s_nxt.addr = '0;
            s_nxt.bit_idx = 3'h0;
            s_nxt.terminal_count = 1'b0;
         end
      endcase
      word = mem_r[s_nxt.addr];
      if (byte_mode) begin
         s_nxt.drv = word;
      end else begin
         s_nxt.drv = {{(DATA_W - 1){1'b0}}, pick_bit(word, s_nxt.bit_idx)};
      end
      // data released in reset, standby and past the last word
      // the rise that passes the last word already lets go, or the loader reads it twice
      s_nxt.oe = (s_nxt.st == DEV_ACTIVE) & ~s_nxt.terminal_count;
      // hands the chain on only when enabled, out of reset and past the end
      s_nxt.cso_n = ~(s_nxt.terminal_count & ~link.chip_enable_n & ~in_reset);
      // open-drain pull while this end is still in its own reset
      s_nxt.rst_oe = (s_nxt.hold != 4'h0);
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_r <= DEV_INIT;
      end else begin
         s_r <= s_nxt;
      end
   end

   // stands in for in-system programming, which this block leaves out
   always_ff @(posedge ref_clk_in) begin
      if (prog_we_in) begin
         mem_r[prog_addr_in] <= prog_data_in;
      end
   end

   assign link.data_drv = s_r.drv;
   assign link.data_oe = s_r.oe;
   assign link.cascade_select_out_n = s_r.cso_n;
   assign link.rst_dev_out = 1'b0;
   assign link.rst_dev_oe = s_r.rst_oe;
   assign addr_out = s_r.addr;
   assign bit_index_out = s_r.bit_idx;
   assign standby_out = (s_r.st == DEV_STANDBY);
   assign terminal_count_out = s_r.terminal_count;
endmodule // cfgprm_mem_end

//--- design/cfgprm_ldr_end.sv
/*
 * loader end: resets the memory, makes the configuration clock, counts
 * pulses and captures bits or bytes into a fifo for the user side.
 * assumes the memory end shares ref_clk_in; a full fifo stalls the clock.
 */
`timescale 1ns/100ps
module cfgprm_ldr_end #(
   parameter int LEN_W = cfgprm_pkg::LEN_W,
   parameter int FIFO_DEPTH = cfgprm_pkg::FIFO_DEPTH,
   parameter int HALF_CYC = cfgprm_pkg::CONF_CLK_HALF_CYC
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   cfgprm_link_if.ldr link,
   input wire logic start_in,
   input wire logic byte_mode_in,
   input wire logic [LEN_W-1:0] pulse_count_in,
   output logic [cfgprm_pkg::DATA_W-1:0] data_out,
   output logic data_valid_out,
   input wire logic data_ready_in,
   output logic busy_out,
   output logic done_out
);
   import cfgprm_pkg::*;

   typedef struct packed {
      cfgprm_ldr_state_e st;
      logic [HALF_W-1:0] half_cnt;
      logic conf_clk;
      logic ce_n;
      logic mode_b;
      logic rst_oe;
      logic [3:0] rst_cnt;
      logic [LEN_W-1:0] left;
      logic [DATA_W-1:0] shreg;
      logic [2:0] bits;
      logic push;
      logic [DATA_W-1:0] push_data;
      logic done;
   } cfgprm_ldr_s;

   localparam logic [HALF_W-1:0] HALF_LOAD = (HALF_W)'(HALF_CYC - 1);

   cfgprm_ldr_s s_r;
   cfgprm_ldr_s s_nxt;
   logic fifo_ready;
   logic [DATA_W-1:0] shifted;

   always_comb begin
      s_nxt = s_r;
      s_nxt.push = 1'b0;
      shifted = {s_r.shreg[DATA_W-2:0], link.serial_data_out};
      case (s_r.st)
         LDR_IDLE, LDR_DONE: begin
            if (start_in) begin
               s_nxt.st = LDR_RESET;
               s_nxt.rst_oe = 1'b1;
               s_nxt.rst_cnt = RST_PULSE_CNT;
               s_nxt.ce_n = 1'b1;
               s_nxt.mode_b = byte_mode_in ? MODE_BYTE : MODE_SERIAL;
               s_nxt.left = pulse_count_in;
               s_nxt.bits = 3'h0;
               s_nxt.shreg = '0;
               s_nxt.done = 1'b0;
            end
         end
         LDR_RESET: begin
            s_nxt.rst_cnt = s_r.rst_cnt - 4'h1;
            if (s_r.rst_cnt == 4'h1) begin
               s_nxt.rst_oe = 1'b0;
               s_nxt.ce_n = 1'b0; // first memory of the chain
               s_nxt.st = LDR_WAIT;
            end
         end
         LDR_WAIT: begin
            // the memory may still pull the pin low after we let go
            if (link.reset_level) begin
               s_nxt.st = (s_r.left == '0) ? LDR_DONE : LDR_RUN;
               s_nxt.done = (s_r.left == '0);
               // an empty load lets the memory go straight back to standby
               s_nxt.ce_n = (s_r.left == '0);
               s_nxt.half_cnt = HALF_LOAD;
            end
         end
         LDR_RUN: begin
            if (s_r.half_cnt != '0) begin
               s_nxt.half_cnt = s_r.half_cnt - 1'b1;
            end else if (s_r.conf_clk) begin
               s_nxt.conf_clk = 1'b0;
               s_nxt.half_cnt = HALF_LOAD;
               if (s_r.left == '0) begin
                  s_nxt.st = LDR_DONE; // stops after the exact count
                  s_nxt.done = 1'b1;
                  s_nxt.ce_n = 1'b1;
               end
            end else if (fifo_ready) begin
               // rising edge captures what the previous edge put out
               s_nxt.conf_clk = 1'b1;
               s_nxt.half_cnt = HALF_LOAD;
               s_nxt.left = s_r.left - 1'b1;
               if (s_r.mode_b == MODE_BYTE) begin
                  s_nxt.push = 1'b1;
                  s_nxt.push_data = link.parallel_data_bus;
               end else begin
                  s_nxt.shreg = shifted;
                  s_nxt.bits = s_r.bits + 3'h1;
                  // a short last byte is pushed as it stands
                  if ((s_r.bits == BIT_LAST) || (s_r.left == (LEN_W)'(1))) begin
                     s_nxt.push = 1'b1;
                     s_nxt.push_data = shifted;
                     // cleared so a short last byte carries no stale bits
                     s_nxt.shreg = '0;
                  end
               end
            end
         end
         default: begin
            s_nxt.st = LDR_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_r <= '{st: LDR_IDLE, ce_n: 1'b1, mode_b: MODE_SERIAL, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   // a full fifo holds the clock low, so the memory simply waits
   cfgprm_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(s_r.push),
      .in_ready_out(fifo_ready),
      .in_data_in(s_r.push_data),
      .out_valid_out(data_valid_out),
      .out_ready_in(data_ready_in),
      .out_data_out(data_out)
   );

   assign link.config_clock = s_r.conf_clk;
   assign link.chip_enable_n = s_r.ce_n;
   assign link.byte_wide_mode_b = s_r.mode_b;
   assign link.rst_ldr_out = 1'b0;
   assign link.rst_ldr_oe = s_r.rst_oe;
   assign busy_out = ~(s_r.st == LDR_IDLE) & ~(s_r.st == LDR_DONE);
   assign done_out = s_r.done;
endmodule // cfgprm_ldr_end

//--- tb/cfgprm_props.sv
/* link checker for memory end and loader end.
   assumes one reference clock; takes the link signals as plain inputs. */
`timescale 1ns/100ps
module cfgprm_props (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic config_clock,
   input wire logic chip_enable_n,
   input wire logic byte_wide_mode_b,
   input wire logic [cfgprm_pkg::DATA_W-1:0] data_drv,
   input wire logic data_oe,
   input wire logic cascade_select_out_n,
   input wire logic rst_dev_out,
   input wire logic rst_dev_oe,
   input wire logic rst_ldr_out,
   input wire logic rst_ldr_oe,
   input wire logic reset_level
);
   import cfgprm_pkg::*;
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_bus_reset_off: assert property (!reset_level |=> !data_oe)
      else $error("bus driven while reset pin low");
   a_bus_standby_off: assert property (chip_enable_n |=> !data_oe)
      else $error("bus driven in standby");
   a_cso_gated: assert property ((chip_enable_n || !reset_level) |=> cascade_select_out_n)
      else $error("cascade output low without enable");
   a_dev_hold_pin: assert property ($rose(rst_n_in) |-> rst_dev_oe [*4] ##[1:6] !rst_dev_oe)
      else $error("reset pin hold wrong");
   a_open_drain_only: assert property (!((rst_dev_oe && rst_dev_out) || (rst_ldr_oe && rst_ldr_out)))
      else $error("reset pin driven high");
   // no rise seen for a while, so the word must not move
   a_data_hold: assert property ((data_oe && $stable(config_clock)) [*4] |-> $stable(data_drv))
      else $error("data changed without clock rise");
   a_serial_bit_zero: assert property (data_oe && byte_wide_mode_b |-> data_drv[7:1] == 7'h00)
      else $error("serial upper bits not zero");
   a_clock_idle: assert property (chip_enable_n [*2] |-> !config_clock)
      else $error("clock pulses outside a load");
   a_mode_fixed: assert property (!chip_enable_n && !$past(chip_enable_n) |-> $stable(byte_wide_mode_b))
      else $error("mode changed during load");

   c_past_tc: cover property (!cascade_select_out_n);
   c_byte_rise: cover property (!byte_wide_mode_b && $rose(config_clock));
   c_stalled: cover property ((data_oe && !config_clock) [*8]);
   c_hold_end: cover property ($fell(rst_dev_oe));
endmodule // cfgprm_props

//--- tb/config_prom_readout_test.sv
/* self-checking bench: memory end and loader end joined by the link,
   a second memory end driven by hand. assumes a 10 MHz reference clock. */
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %0t got %h want %h", $time, g, e); end end
module config_prom_readout_test;
   import cfgprm_pkg::*;
   localparam int MD = 32;
   logic ref_clk_in = 1'b0, rst_n_in = 1'b0, start_in = 1'b0, byte_mode_in = 1'b0;
   logic data_ready_in = 1'b0, prog_we = 1'b0;
   logic [4:0] prog_addr = 5'h00;
   logic [7:0] prog_data = 8'h00;
   logic [15:0] pulse_count_in = 16'h0000;
   logic [7:0] data_out;
   logic data_valid_out, busy_out, done_out, sb2;
   logic [4:0] addr2;
   logic [7:0] img [MD];
   int errors = 0, n_checks = 0, seed = 32'h47DC;

   cfgprm_link_if lnk ();
   cfgprm_link_if lnk2 ();
   cfgprm_mem_end #(.DEPTH(MD)) cfgprm_mem_end_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link(lnk),
      .prog_we_in(prog_we), .prog_addr_in(prog_addr), .prog_data_in(prog_data), .addr_out(),
      .bit_index_out(), .standby_out(), .terminal_count_out());
   if (1) begin : hand
      cfgprm_mem_end #(.DEPTH(MD)) cfgprm_mem_end_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
         .link(lnk2), .prog_we_in(prog_we), .prog_addr_in(prog_addr), .prog_data_in(prog_data),
         .addr_out(addr2), .bit_index_out(), .standby_out(sb2), .terminal_count_out());
   end
   cfgprm_ldr_end cfgprm_ldr_end_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link(lnk),
      .start_in(start_in), .byte_mode_in(byte_mode_in), .pulse_count_in(pulse_count_in), .data_out(data_out),
      .data_valid_out(data_valid_out), .data_ready_in(data_ready_in), .busy_out(busy_out), .done_out(done_out));
   cfgprm_props cfgprm_props_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .config_clock(lnk.config_clock), .chip_enable_n(lnk.chip_enable_n),
      .byte_wide_mode_b(lnk.byte_wide_mode_b), .data_drv(lnk.data_drv), .data_oe(lnk.data_oe),
      .cascade_select_out_n(lnk.cascade_select_out_n), .rst_dev_out(lnk.rst_dev_out),
      .rst_dev_oe(lnk.rst_dev_oe), .rst_ldr_out(lnk.rst_ldr_out), .rst_ldr_oe(lnk.rst_ldr_oe),
      .reset_level(lnk.reset_level));

   initial forever #50 ref_clk_in = ~ref_clk_in;

   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // past the last word the bus floats to the pull-up
   function automatic logic [7:0] exp_word(logic bm, int j, int n);
      logic [7:0] v;
      v = 8'h00;
      if (bm)
         return (j < MD) ? img[j] : 8'hFF;
      for (int i = 8 * j; i < 8 * j + 8 && i < n; i++)
         v = {v[6:0], (i < 8 * MD) ? img[i / 8][7 - i % 8] : 1'b1};
      return v;
   endfunction

   task automatic run_load(logic bm, int n, logic stall);
      int got, rises, nw, rs;
      logic cso_low, prev;
      got = 0;
      rises = 0;
      rs = 0;
      cso_low = 1'b0;
      prev = 1'b0;
      nw = bm ? n : (n + 7) / 8;
      @(posedge ref_clk_in);
      start_in <= 1'b1;
      byte_mode_in <= bm;
      pulse_count_in <= n[15:0];
      @(posedge ref_clk_in);
      start_in <= 1'b0;
      for (int c = 0; c < 20000 && !(got == nw && done_out === 1'b1); c++) begin
         @(posedge ref_clk_in);
         if (data_valid_out === 1'b1 && data_ready_in) begin
            `CHK(data_out, exp_word(bm, got, n))
            got++;
         end
         if (lnk.config_clock && !prev)
            rises++;
         prev = lnk.config_clock;
         if (lnk.cascade_select_out_n === 1'b0)
            cso_low = 1'b1;
         if (c == 80)
            rs = rises;
         // a full fifo must freeze the clock, not drop data
         if (c == 100 && stall) begin
            `CHK(rises, rs)
            `CHK(data_valid_out, 1'b1)
         end
         data_ready_in <= (c >= 100 || !stall) && ($random(seed) % 4 != 0);
      end
      if (got != nw || done_out !== 1'b1) begin
         errors++;
         $display("[ERR] %0t load did not finish", $time);
         end_of_test();
      end
      `CHK(rises, n)
      `CHK(cso_low, n >= (bm ? MD : 8 * MD))
      repeat (3) @(posedge ref_clk_in);
      `CHK(lnk.chip_enable_n, 1'b1)
      `CHK(lnk.parallel_data_bus, 8'hFF)
      `CHK(data_valid_out, 1'b0)
      `CHK(busy_out, 1'b0)
   endtask

   task automatic pulse2(int k);
      repeat (k) begin
         @(posedge ref_clk_in);
         lnk2.config_clock <= 1'b1;
         repeat (2) @(posedge ref_clk_in);
         lnk2.config_clock <= 1'b0;
         repeat (2) @(posedge ref_clk_in);
      end
   endtask

   initial begin
      int r;
      lnk2.config_clock = 1'b0;
      lnk2.chip_enable_n = 1'b1;
      lnk2.byte_wide_mode_b = 1'b0;
      lnk2.rst_ldr_out = 1'b0;
      lnk2.rst_ldr_oe = 1'b0;
      for (int i = 0; i < MD; i++)
         img[i] = 8'($random(seed));
      img[1] = 8'h00;
      img[2] = 8'hFF;
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < MD; i++) begin
         @(posedge ref_clk_in);
         prog_we <= 1'b1;
         prog_addr <= i[4:0];
         prog_data <= img[i];
      end
      @(posedge ref_clk_in);
      prog_we <= 1'b0;
      run_load(1'b1, MD, 1'b0);
      run_load(1'b1, MD + 3, 1'b0);
      run_load(1'b1, 40, 1'b1);
      run_load(1'b0, 13, 1'b0);
      run_load(1'b0, 8 * MD + 5, 1'b0);
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         run_load(r[0], 1 + {r[15:8]} + {r[2:1]}, 1'b0);
      end
      // hand-driven end: enable, standby and reset pin
      lnk2.chip_enable_n <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      `CHK(lnk2.parallel_data_bus, img[0])
      pulse2(3);
      `CHK(addr2, 5'h03)
      `CHK(lnk2.parallel_data_bus, img[3])
      lnk2.chip_enable_n <= 1'b1;
      pulse2(2);
      `CHK(addr2, 5'h00)
      `CHK(sb2, 1'b1)
      `CHK(lnk2.parallel_data_bus, 8'hFF)
      lnk2.chip_enable_n <= 1'b0;
      lnk2.byte_wide_mode_b <= 1'b1;
      pulse2(1);
      `CHK(lnk2.serial_data_out, img[0][6])
      lnk2.rst_ldr_oe <= 1'b1;
      pulse2(2);
      `CHK(lnk2.reset_level, 1'b0)
      `CHK(addr2, 5'h00)
      `CHK(lnk2.parallel_data_bus, 8'hFF)
      lnk2.rst_ldr_oe <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      `CHK(lnk2.serial_data_out, img[0][7])
      // second reset in mid-run
      rst_n_in <= 1'b0;
      repeat (3) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      `CHK(lnk.reset_level, 1'b0)
      run_load(1'b0, 24, 1'b0);
      end_of_test();
   end
endmodule // config_prom_readout_test
